/* mpc_consts.svh */
`ifndef MPC_CONSTS_SVH
`define MPC_CONSTS_SVH
// Operation
// - bit 0 connects left positive pin, resets 1
// - bit 1 connects left inverting pin, resets 1
// - bit 2 connects left second pin, resets 0
// - bit 8 connects right positive pin, resets 1
// - bit 9 connects right inverting pin, resets 1
// - bit 10 connects right second pin, resets 0
// - one gain per amplifier feeds all pins
// - left bit 14 mutes left amplifier
// - right bit 14 mutes right amplifier
// - left bit 13 defers gain to zero cross
// - right bit 13 defers gain to zero cross
// - gains wait for update bit, both together
// - left gain bits 7:2, reset 0x10
// - right gain same layout and reset
// - power one bit 4 enables bias output
// - bias enable shared with bias bit 15
// - bias bit 14 selects bias level
// - codec enable clear holds registers in reset
// - preamp enables aliased power two and volume

// register indices; byte address is four times the index
`define MPC_IDX_PWR_ONE 8'h08
`define MPC_IDX_PWR_TWO 8'h09
`define MPC_IDX_PWR_FIVE 8'h0c
`define MPC_IDX_PIN_SEL 8'h48
`define MPC_IDX_BIAS 8'h4a
`define MPC_IDX_LEFT_VOL 8'h50
`define MPC_IDX_RIGHT_VOL 8'h51

// field positions
`define MPC_BIT_LEFT_POS 0
`define MPC_BIT_LEFT_NEG 1
`define MPC_BIT_LEFT_SEC 2
`define MPC_BIT_RIGHT_POS 8
`define MPC_BIT_RIGHT_NEG 9
`define MPC_BIT_RIGHT_SEC 10
`define MPC_BIT_VOL_ON 15
`define MPC_BIT_MUTE 14
`define MPC_BIT_ZC 13
`define MPC_BIT_VU 8
`define MPC_GAIN_MSB 7
`define MPC_GAIN_LSB 2
`define MPC_BIT_BIAS_PM1 4
`define MPC_BIT_BIAS_ALT 15
`define MPC_BIT_BIAS_SEL 14
`define MPC_BIT_LEFT_ON_PM2 8
`define MPC_BIT_RIGHT_ON_PM2 9
`define MPC_BIT_CODEC_ON 12

// reset values
`define MPC_GAIN_RST 6'h10
`define MPC_PINS_RST 3'h3
`endif

/* mpc_gain_stage.sv */
`timescale 1ns/1ps
`include "mpc_consts.svh"
module mpc_gain_stage (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic hold_in,
  input wire logic commit_in,
  input wire logic zc_mode_in,
  input wire logic zero_cross_in,
  input wire mpc_pkg::mpc_gain_t pend_gain_in,
  output mpc_pkg::mpc_gain_t applied_gain_out,
  output logic armed_out
);
  import mpc_pkg::*;
  mpc_gain_state_t state; // idle or waiting for a crossing
  mpc_gain_t target; // gain captured at the commit

  // target is latched at commit so later writes stay pending
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= MPC_GS_IDLE;
      target <= `MPC_GAIN_RST;
      applied_gain_out <= `MPC_GAIN_RST;
    end else if (hold_in) begin
      state <= MPC_GS_IDLE;
      target <= `MPC_GAIN_RST;
      applied_gain_out <= `MPC_GAIN_RST;
    end else if (commit_in) begin
      target <= pend_gain_in;
      if (zc_mode_in) begin
        state <= MPC_GS_ARMED;
      end else begin
        state <= MPC_GS_IDLE;
        applied_gain_out <= pend_gain_in;
      end
    end else begin
      case (state)
        MPC_GS_ARMED: begin
          if (zero_cross_in) begin
            applied_gain_out <= target;
            state <= MPC_GS_IDLE;
          end
        end
        default: begin
          state <= MPC_GS_IDLE;
        end
      endcase
    end
  end

  assign armed_out = (state == MPC_GS_ARMED);

  AST_ZC_APPLY: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (armed_out && zero_cross_in && !commit_in && !hold_in) |=> (applied_gain_out == $past(target)) && !armed_out)
    else $error("deferred gain not applied at zero crossing");
endmodule

/* mpc_host_model.sv */
`timescale 1ns/1ps
// apb master standing in for the host software
module mpc_host_model (
  input wire logic clock_in,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [11:0] paddr_out,
  output logic [31:0] pwdata_out
);
  // idle bus from time zero
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0;
  end

  // one transfer; request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data,
                      output logic [31:0] rdata, output logic err);
    @(posedge clock_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= wr;
    paddr_out <= addr;
    pwdata_out <= data;
    @(posedge clock_in);
    penable_out <= 1'b1;
    // no fixed latency assumed, the bench watchdog ends a hang
    do begin
      @(posedge clock_in);
    end while (pready_in !== 1'b1);
    rdata = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // released lines show junk so stale values are never trusted
    paddr_out <= ~addr;
    pwdata_out <= ~data;
  endtask
endmodule

/* mpc_mic_input_ctrl.sv */
`timescale 1ns/1ps
`include "mpc_consts.svh"
module mpc_mic_input_ctrl #(
  parameter int ADDR_W = 12
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic left_zero_cross_in,
  input wire logic right_zero_cross_in,
  output logic left_pos_pin_connect_out,
  output logic left_neg_pin_connect_out,
  output logic left_second_pin_connect_out,
  output logic right_pos_pin_connect_out,
  output logic right_neg_pin_connect_out,
  output logic right_second_pin_connect_out,
  output logic left_preamp_silence_out,
  output logic right_preamp_silence_out,
  output mpc_pkg::mpc_gain_t left_preamp_gain_out,
  output mpc_pkg::mpc_gain_t right_preamp_gain_out,
  output logic left_preamp_on_out,
  output logic right_preamp_on_out,
  output logic bias_output_on_out,
  output logic bias_level_select_out,
  output logic codec_master_on_out
);
  import mpc_pkg::*;

  // register state
  logic codec_on; // master codec enable, never self-cleared
  logic [2:0] left_pins; // second, neg, pos connects
  logic [2:0] right_pins; // second, neg, pos connects
  logic bias_on; // single bit behind two addresses
  logic bias_sel; // bias level choice
  logic commit; // one-cycle gain update strobe
  logic mute [2]; // per channel mute
  logic zc_mode [2]; // per channel deferred update
  logic preamp_on [2]; // per channel amplifier enable
  mpc_gain_t pend_gain [2]; // written, not yet applied
  mpc_gain_t live_gain [2]; // gain the amplifier sees
  logic armed [2]; // waiting for a zero crossing
  logic [1:0] zc_pin; // raw comparator levels

  // decode
  logic [7:0] idx; // word index
  logic aligned; // low and high address bits clear
  logic mapped; // index names a register here
  logic [31:0] next_rdata; // read mux result
  logic wr_en; // access phase of a write
  logic wr_ok; // write that may land
  logic wr_pm1; // power one write
  logic wr_pm2; // power two write
  logic wr_pm5; // power five write
  logic wr_pin; // pin select write
  logic wr_bias; // bias control write
  logic wr_vol [2]; // volume register writes
  logic vu_hit; // update bit written to either volume

  assign idx = paddr_in[9:2];
  assign aligned = (paddr_in[1:0] == 2'h0) && (paddr_in[ADDR_W-1:10] == '0);
  assign wr_en = psel_in && penable_in && pwrite_in;
  // writes other than power five are dropped while the codec is off, the clear wins anyway
  assign wr_ok = wr_en && mapped && codec_on;
  assign wr_pm1 = wr_ok && (idx == `MPC_IDX_PWR_ONE);
  assign wr_pm2 = wr_ok && (idx == `MPC_IDX_PWR_TWO);
  assign wr_pm5 = wr_en && mapped && (idx == `MPC_IDX_PWR_FIVE);
  assign wr_pin = wr_ok && (idx == `MPC_IDX_PIN_SEL);
  assign wr_bias = wr_ok && (idx == `MPC_IDX_BIAS);
  assign wr_vol[0] = wr_ok && (idx == `MPC_IDX_LEFT_VOL);
  assign wr_vol[1] = wr_ok && (idx == `MPC_IDX_RIGHT_VOL);
  assign vu_hit = (wr_vol[0] || wr_vol[1]) && pwdata_in[`MPC_BIT_VU];

  // zero-wait slave, error only on unmapped addresses
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;

  // read mux; bits not listed read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    mapped = 1'b1;
    if (!aligned) begin
      mapped = 1'b0;
    end else if (idx == `MPC_IDX_PWR_ONE) begin
      next_rdata[`MPC_BIT_BIAS_PM1] = bias_on;
    end else if (idx == `MPC_IDX_PWR_TWO) begin
      next_rdata[`MPC_BIT_LEFT_ON_PM2] = preamp_on[0];
      next_rdata[`MPC_BIT_RIGHT_ON_PM2] = preamp_on[1];
    end else if (idx == `MPC_IDX_PWR_FIVE) begin
      next_rdata[`MPC_BIT_CODEC_ON] = codec_on;
    end else if (idx == `MPC_IDX_PIN_SEL) begin
      next_rdata[`MPC_BIT_LEFT_POS] = left_pins[0];
      next_rdata[`MPC_BIT_LEFT_NEG] = left_pins[1];
      next_rdata[`MPC_BIT_LEFT_SEC] = left_pins[2];
      next_rdata[`MPC_BIT_RIGHT_POS] = right_pins[0];
      next_rdata[`MPC_BIT_RIGHT_NEG] = right_pins[1];
      next_rdata[`MPC_BIT_RIGHT_SEC] = right_pins[2];
    end else if (idx == `MPC_IDX_BIAS) begin
      next_rdata[`MPC_BIT_BIAS_ALT] = bias_on;
      next_rdata[`MPC_BIT_BIAS_SEL] = bias_sel;
    end else if (idx == `MPC_IDX_LEFT_VOL) begin
      next_rdata[`MPC_BIT_VOL_ON] = preamp_on[0];
      next_rdata[`MPC_BIT_MUTE] = mute[0];
      next_rdata[`MPC_BIT_ZC] = zc_mode[0];
      next_rdata[`MPC_GAIN_MSB:`MPC_GAIN_LSB] = pend_gain[0];
    end else if (idx == `MPC_IDX_RIGHT_VOL) begin
      next_rdata[`MPC_BIT_VOL_ON] = preamp_on[1];
      next_rdata[`MPC_BIT_MUTE] = mute[1];
      next_rdata[`MPC_BIT_ZC] = zc_mode[1];
      next_rdata[`MPC_GAIN_MSB:`MPC_GAIN_LSB] = pend_gain[1];
    end else begin
      mapped = 1'b0;
    end
  end

  // read data captured in the setup cycle, stable through access
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_out <= next_rdata;
    end
  end

  // master enable lives outside the held group
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      codec_on <= 1'b0;
    end else if (wr_pm5) begin
      codec_on <= pwdata_in[`MPC_BIT_CODEC_ON];
    end
  end

  // pin connections, both channels in one register
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      left_pins <= `MPC_PINS_RST;
      right_pins <= `MPC_PINS_RST;
    end else if (!codec_on) begin
      left_pins <= `MPC_PINS_RST;
      right_pins <= `MPC_PINS_RST;
    end else if (wr_pin) begin
      left_pins[0] <= pwdata_in[`MPC_BIT_LEFT_POS];
      left_pins[1] <= pwdata_in[`MPC_BIT_LEFT_NEG];
      left_pins[2] <= pwdata_in[`MPC_BIT_LEFT_SEC];
      right_pins[0] <= pwdata_in[`MPC_BIT_RIGHT_POS];
      right_pins[1] <= pwdata_in[`MPC_BIT_RIGHT_NEG];
      right_pins[2] <= pwdata_in[`MPC_BIT_RIGHT_SEC];
    end
  end

  // bias enable reachable from both addresses, never both at once
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bias_on <= 1'b0;
      bias_sel <= 1'b0;
    end else if (!codec_on) begin
      bias_on <= 1'b0;
      bias_sel <= 1'b0;
    end else if (wr_pm1) begin
      bias_on <= pwdata_in[`MPC_BIT_BIAS_PM1];
    end else if (wr_bias) begin
      bias_on <= pwdata_in[`MPC_BIT_BIAS_ALT];
      bias_sel <= pwdata_in[`MPC_BIT_BIAS_SEL];
    end
  end

  // update bit is a strobe; delayed a cycle so pending gains have landed
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      commit <= 1'b0;
    end else if (!codec_on) begin
      commit <= 1'b0;
    end else begin
      commit <= vu_hit;
    end
  end

  assign zc_pin = {right_zero_cross_in, left_zero_cross_in};

  // per channel volume register, crossing sync and gain stage
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    localparam int ON_PM2 = (ch == 0) ? `MPC_BIT_LEFT_ON_PM2 : `MPC_BIT_RIGHT_ON_PM2;
    logic crossing; // synchronised zero crossing pulse

    // volume fields; the update bit itself is not stored
    always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        mute[ch] <= 1'b0;
        zc_mode[ch] <= 1'b0;
        pend_gain[ch] <= `MPC_GAIN_RST;
      end else if (!codec_on) begin
        mute[ch] <= 1'b0;
        zc_mode[ch] <= 1'b0;
        pend_gain[ch] <= `MPC_GAIN_RST;
      end else if (wr_vol[ch]) begin
        mute[ch] <= pwdata_in[`MPC_BIT_MUTE];
        zc_mode[ch] <= pwdata_in[`MPC_BIT_ZC];
        pend_gain[ch] <= pwdata_in[`MPC_GAIN_MSB:`MPC_GAIN_LSB];
      end
    end

    // amplifier enable shared by power two and the volume register
    always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        preamp_on[ch] <= 1'b0;
      end else if (!codec_on) begin
        preamp_on[ch] <= 1'b0;
      end else if (wr_pm2) begin
        preamp_on[ch] <= pwdata_in[ON_PM2];
      end else if (wr_vol[ch]) begin
        preamp_on[ch] <= pwdata_in[`MPC_BIT_VOL_ON];
      end
    end

    // comparator level is asynchronous to the codec clock
    mpc_sync_edge u_sync (
      .clock_in(clock_in),
      .rst_b_in(rst_b_in),
      .async_in(zc_pin[ch]),
      .edge_out(crossing)
    );

    // one gain drives the amplifier whatever pins feed it
    mpc_gain_stage u_gain (
      .clock_in(clock_in),
      .rst_b_in(rst_b_in),
      .hold_in(!codec_on),
      .commit_in(commit),
      .zc_mode_in(zc_mode[ch]),
      .zero_cross_in(crossing),
      .pend_gain_in(pend_gain[ch]),
      .applied_gain_out(live_gain[ch]),
      .armed_out(armed[ch])
    );
  end

  // outputs, all from flops
  assign left_pos_pin_connect_out = left_pins[0];
  assign left_neg_pin_connect_out = left_pins[1];
  assign left_second_pin_connect_out = left_pins[2];
  assign right_pos_pin_connect_out = right_pins[0];
  assign right_neg_pin_connect_out = right_pins[1];
  assign right_second_pin_connect_out = right_pins[2];
  assign left_preamp_silence_out = mute[0];
  assign right_preamp_silence_out = mute[1];
  assign left_preamp_gain_out = live_gain[0];
  assign right_preamp_gain_out = live_gain[1];
  assign left_preamp_on_out = preamp_on[0];
  assign right_preamp_on_out = preamp_on[1];
  // analogue side turns a clear enable into a floating bias pin
  assign bias_output_on_out = bias_on;
  assign bias_level_select_out = bias_sel;
  assign codec_master_on_out = codec_on;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);

  AST_PIN_WRITE: assert property (
    wr_pin |=> (left_pins == $past(pwdata_in[2:0])) && (right_pins == $past(pwdata_in[10:8])))
    else $error("pin select write not stored");

  AST_HELD_OFF: assert property (
    !codec_on |=> (left_pins == `MPC_PINS_RST) && (right_pins == `MPC_PINS_RST) && !bias_on && !mute[0]
      && !preamp_on[1] && (pend_gain[1] == `MPC_GAIN_RST))
    else $error("registers not held while codec off");

  AST_GAIN_RESET: assert property (
    !codec_on |=> (left_preamp_gain_out == `MPC_GAIN_RST) && (right_preamp_gain_out == `MPC_GAIN_RST))
    else $error("applied gain not at reset value");

  AST_MUTE_LEFT: assert property (
    wr_vol[0] |=> left_preamp_silence_out == $past(pwdata_in[`MPC_BIT_MUTE]))
    else $error("left mute not taken");

  AST_MUTE_RIGHT: assert property (
    wr_vol[1] |=> right_preamp_silence_out == $past(pwdata_in[`MPC_BIT_MUTE]))
    else $error("right mute not taken");

  AST_COMMIT_NOW: assert property (
    (commit && !zc_mode[0] && !zc_mode[1] && codec_on) |=>
      (live_gain[0] == $past(pend_gain[0])) && (live_gain[1] == $past(pend_gain[1])))
    else $error("immediate commit did not update both gains");

  AST_GAIN_WAITS: assert property (
    (codec_on && !commit && !armed[0]) |=> $stable(left_preamp_gain_out))
    else $error("left gain changed without update strobe");

  AST_ZC_DEFER: assert property (
    (commit && zc_mode[0] && codec_on && (live_gain[0] != pend_gain[0])) |=> armed[0])
    else $error("deferred update did not arm");

  AST_VU_PULSE: assert property (
    vu_hit |=> commit ##1 (!commit || $past(vu_hit)))
    else $error("update strobe not a single pulse");

  AST_VU_READ_ZERO: assert property (
    (psel_in && !penable_in && !pwrite_in && aligned && (idx == `MPC_IDX_RIGHT_VOL)) |=> !prdata_out[`MPC_BIT_VU])
    else $error("update bit reads back as set");

  AST_BIAS_PM1: assert property (
    wr_pm1 |=> bias_output_on_out == $past(pwdata_in[`MPC_BIT_BIAS_PM1]))
    else $error("bias enable not written via power one");

  AST_BIAS_ALT: assert property (
    wr_bias |=> (bias_output_on_out == $past(pwdata_in[`MPC_BIT_BIAS_ALT]))
      && (bias_level_select_out == $past(pwdata_in[`MPC_BIT_BIAS_SEL])))
    else $error("bias control write not shared");

  AST_PREAMP_ALIAS: assert property (
    wr_pm2 |=> (left_preamp_on_out == $past(pwdata_in[`MPC_BIT_LEFT_ON_PM2]))
      && (right_preamp_on_out == $past(pwdata_in[`MPC_BIT_RIGHT_ON_PM2])))
    else $error("preamp enable alias broken");

  AST_SLVERR: assert property (
    (psel_in && penable_in && !aligned) |-> pslverr_out)
    else $error("misaligned access not refused");

  // master enable must follow its own write even while the rest is held
  AST_CODEC_ON: assert property (
    wr_pm5 |=> codec_master_on_out == $past(pwdata_in[`MPC_BIT_CODEC_ON]))
    else $error("codec enable write not stored");

  // right channel arming mirrors the left one
  AST_ZC_DEFER_RIGHT: assert property (
    (commit && zc_mode[1] && codec_on && (live_gain[1] != pend_gain[1])) |=> armed[1])
    else $error("right deferred update did not arm");

  // the volume register copy of the amplifier enable reaches the same flop
  AST_LEFT_ON_VOL: assert property (
    wr_vol[0] |=> left_preamp_on_out == $past(pwdata_in[`MPC_BIT_VOL_ON]))
    else $error("left enable not taken from volume register");

  AST_RIGHT_ON_VOL: assert property (
    wr_vol[1] |=> right_preamp_on_out == $past(pwdata_in[`MPC_BIT_VOL_ON]))
    else $error("right enable not taken from volume register");

  // mute and zero-cross mode act at once, not through the update strobe
  AST_ZC_MODE_RIGHT: assert property (
    wr_vol[1] |=> zc_mode[1] == $past(pwdata_in[`MPC_BIT_ZC]))
    else $error("right zero-cross mode not taken");
endmodule

/* mpc_pkg.sv */
package mpc_pkg;
  // six-bit preamp gain code, 0.75 dB steps from -12 dB
  typedef logic [5:0] mpc_gain_t;
  // gain stage states, one-hot
  typedef enum logic [1:0] {
    MPC_GS_IDLE = 2'b01,
    MPC_GS_ARMED = 2'b10
  } mpc_gain_state_t;
endpackage

/* mpc_sync_edge.sv */
`timescale 1ns/1ps
module mpc_sync_edge (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic async_in,
  output logic edge_out
);
  import mpc_pkg::*;
  logic meta; // first stage, read only by stage two
  logic stable; // second stage
  logic prev; // delayed copy for edge detection

  // two-flop synchroniser plus history flop
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= async_in;
      stable <= meta;
      prev <= stable;
    end
  end

  // any change of the comparator sign marks a zero crossing
  assign edge_out = stable ^ prev;
endmodule

/* testbench.sv */
`timescale 1ns/1ps
`include "mpc_consts.svh"
module testbench;
  import mpc_pkg::*;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic lzc = 1'b0;
  logic rzc = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic lp, ln, ls, rp, rn, rs, lmute, rmute, lon, ron, bon, bsel, con;
  mpc_gain_t lgain, rgain, gl, gr, g;
  int miscompares = 0;
  int n_checks = 0;
  int seed = 32'hdf1eb5b6;
  logic [31:0] d;

  // 250 MHz clock
  always #2 clock_in = ~clock_in;

  mpc_host_model i_mpc_host_model (.clock_in(clock_in), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata));

  mpc_mic_input_ctrl i_mpc_mic_input_ctrl (.clock_in(clock_in), .rst_b_in(rst_b_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .left_zero_cross_in(lzc),
    .right_zero_cross_in(rzc), .left_pos_pin_connect_out(lp), .left_neg_pin_connect_out(ln),
    .left_second_pin_connect_out(ls), .right_pos_pin_connect_out(rp), .right_neg_pin_connect_out(rn),
    .right_second_pin_connect_out(rs), .left_preamp_silence_out(lmute), .right_preamp_silence_out(rmute),
    .left_preamp_gain_out(lgain), .right_preamp_gain_out(rgain), .left_preamp_on_out(lon),
    .right_preamp_on_out(ron), .bias_output_on_out(bon), .bias_level_select_out(bsel),
    .codec_master_on_out(con));

  // compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // byte address is four times the index
  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // expected volume word, update bit always reads zero
  function automatic logic [31:0] vol(input logic on, input logic mute, input logic zc, input mpc_gain_t gn);
    return {16'h0, on, mute, zc, 5'h00, gn, 2'b00};
  endfunction

  // pin outputs packed like the select register
  function automatic logic [31:0] pins();
    return {21'h0, rs, rn, rp, 5'h00, ls, ln, lp};
  endfunction

  // write, then let the edge's updates land
  task automatic wr(input logic [7:0] idx, input logic [31:0] dw);
    i_mpc_host_model.xfer(1'b1, ba(idx), dw, rd, er);
    #1;
  endtask

  task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    i_mpc_host_model.xfer(1'b0, ba(idx), 32'h0, rd, er);
    check(name, rd, exp);
  endtask

  // cycles after the commit write for the gain to settle
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  // watchdog, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge clock_in);
    miscompares++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge clock_in);
    rst_b_in <= 1'b1;
    rdchk("pin_sel", `MPC_IDX_PIN_SEL, 32'h0303);
    rdchk("left_vol", `MPC_IDX_LEFT_VOL, vol(0, 0, 0, 6'h10));
    rdchk("right_vol", `MPC_IDX_RIGHT_VOL, vol(0, 0, 0, 6'h10));
    rdchk("bias", `MPC_IDX_BIAS, 32'h0);
    check("pready", 32'(pready), 32'h1);
    // pin select writes while the codec is off are dropped
    wr(`MPC_IDX_PIN_SEL, 32'h0404);
    rdchk("pin_sel_off", `MPC_IDX_PIN_SEL, 32'h0303);
    wr(`MPC_IDX_PWR_FIVE, 32'h1000);
    check("codec_on", 32'(con), 32'h1);
    // random pin selects, corner values first
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hffff : (i == 1) ? 32'h0 : $random(seed);
      wr(`MPC_IDX_PIN_SEL, d);
      check("pins", pins(), d & 32'h0707);
      rdchk("pin_rd", `MPC_IDX_PIN_SEL, d & 32'h0707);
    end
    // one bias enable behind two addresses
    wr(`MPC_IDX_PWR_ONE, 32'h0010);
    check("bias_on", 32'(bon), 32'h1);
    rdchk("bias_alias", `MPC_IDX_BIAS, 32'h8000);
    wr(`MPC_IDX_BIAS, 32'h4000);
    check("bias_off", 32'(bon), 32'h0);
    check("bias_sel", 32'(bsel), 32'h1);
    rdchk("pm1_alias", `MPC_IDX_PWR_ONE, 32'h0);
    // preamp enables behind two addresses
    wr(`MPC_IDX_PWR_TWO, 32'h0300);
    check("preamp_on", 32'({lon, ron}), 32'h3);
    rdchk("lvol_on", `MPC_IDX_LEFT_VOL, vol(1, 0, 0, 6'h10));
    // pending gains, committed together by either volume register
    gl = 6'h10;
    gr = 6'h10;
    for (int k = 0; k < 4; k++) begin
      g = (k == 0) ? 6'h3f : (k == 1) ? 6'h00 : 6'($random(seed));
      wr(`MPC_IDX_LEFT_VOL, vol(1, k[0], 0, g));
      check("lgain_pend", 32'(lgain), 32'(gl));
      check("lmute", 32'(lmute), 32'(k[0]));
      gl = g;
      // right pending gain only changes when the right register is written
      if (k < 2) begin
        gr = 6'($random(seed));
        wr(`MPC_IDX_RIGHT_VOL, vol(1, k[1], 0, gr) | 32'h100);
      end else begin
        wr(`MPC_IDX_LEFT_VOL, vol(1, k[0], 0, gl) | 32'h100);
      end
      wait_cyc(3);
      check("lgain", 32'(lgain), 32'(gl));
      check("rgain", 32'(rgain), 32'(gr));
      if (k < 2) begin
        check("rmute", 32'(rmute), 32'(k[1]));
        rdchk("rvol_rd", `MPC_IDX_RIGHT_VOL, vol(1, k[1], 0, gr));
      end
    end
    // zero-cross deferred update, each channel
    for (int ch = 0; ch < 2; ch++) begin
      g = ~((ch == 0) ? gl : gr);
      wr(ch ? `MPC_IDX_RIGHT_VOL : `MPC_IDX_LEFT_VOL, vol(1, 0, 1, g) | 32'h100);
      wait_cyc(8);
      check("zc_hold", 32'(ch ? rgain : lgain), 32'(ch ? gr : gl));
      @(posedge clock_in);
      if (ch == 1) begin
        rzc <= ~rzc;
      end else begin
        lzc <= ~lzc;
      end
      wait_cyc(8);
      check("zc_apply", 32'(ch ? rgain : lgain), 32'(g));
      if (ch == 1) gr = g;
      else gl = g;
    end
    // unmapped index refused
    i_mpc_host_model.xfer(1'b0, 12'h004, 32'h0, rd, er);
    check("unmapped_err", 32'(er), 32'h1);
    check("unmapped_rd", rd, 32'h0);
    // misaligned write refused and dropped
    i_mpc_host_model.xfer(1'b1, ba(`MPC_IDX_PIN_SEL) | 12'h002, 32'h0, rd, er);
    check("misaligned_err", 32'(er), 32'h1);
    check("misaligned_pins", pins(), d & 32'h0707);
    // clearing codec enable returns everything to reset
    wr(`MPC_IDX_PWR_FIVE, 32'h0);
    wait_cyc(2);
    check("pins_rst", pins(), 32'h0303);
    check("gain_rst", 32'({lgain, rgain}), 32'h410);
    check("bias_rst", 32'({bon, bsel, lon, ron, con, lmute, rmute}), 32'h0);
    summarize();
  end
endmodule
